/* core/odc_output_driver_control.sv */
`timescale 1ns/1ps
`include "odc_map.svh"
// What this block does
// (R1) Bit 7 picks the channel driver: 0 differential, 1 two single-ended legs.
// (R2) Reset gives differential, leg field 11 (both legs), noninverting, 780 mV swing, powered up.
// (R3) In single-ended mode bits 6:5 give 01 leg A only, 10 leg B only, 11 both legs.
// (R4) In single-ended mode leg field 00 tristates both legs.
// (R5) Bits 4:3 set leg polarity; differential uses bit 3 only, single-ended all four codes.
// (R6) Bits 2:1 pick the differential swing 400, 600, 780 or 960 mV.
// (R7) Bit 0 set powers the differential driver down safely.
// (R8) Channels 1 to 3 sit at the next addresses with the same layout.
module odc_output_driver_control #(
  parameter int NUM_CH = 4
) (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  input  wire logic [`ODC_ADDR_W-1:0]    addr,
  input  wire logic [7:0]                wr_data,
  output logic      [7:0]                rd_data,
  output logic                           rd_valid,
  output odc_pkg::odc_drive_t [NUM_CH-1:0] drive,
  output logic      [NUM_CH-1:0][9:0]    swing_mv
);
  import odc_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [`ODC_ADDR_W-1:0] a, input int ch);
    hit = (a == (`ODC_CH0_ADDR + ch[`ODC_ADDR_W-1:0])); // R8
  endfunction

  function automatic logic [9:0] mv_of(input logic [1:0] code);
    unique case (code) // R6
      `ODC_SWING_400: mv_of = 10'(`ODC_SWING_400_MV);
      `ODC_SWING_600: mv_of = 10'(`ODC_SWING_600_MV);
      `ODC_SWING_780: mv_of = 10'(`ODC_SWING_780_MV);
      `ODC_SWING_960: mv_of = 10'(`ODC_SWING_960_MV);
    endcase
  endfunction

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  odc_ctrl_t [NUM_CH-1:0] ctrl_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_q[i] <= `ODC_RESET_VAL; // R2
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit(addr, i)) begin
          ctrl_q[i] <= wr_data; // R8
        end
      end
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_data  <= 8'h00;
      if (rd_en) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (hit(addr, i)) begin
            rd_data <= ctrl_q[i];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    odc_channel_decode u_dec (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ctrl     (ctrl_q[g]),
      .drive    (drive[g])
    );

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        swing_mv[g] <= 10'h000;
      end else begin
        swing_mv[g] <= mv_of(ctrl_q[g].differential_swing); // R6
      end
    end

    // ----------------------------------------
    // per-channel checks
    // ----------------------------------------
    sequence s_wr_ch;
      wr_en && hit(addr, g);
    endsequence

    sequence s_rd_ch;
      rd_en && hit(addr, g);
    endsequence

    property p_type_sel;
      @(posedge core_clk) disable iff (!resetn)
        1'b1 |=> (drive[g].diff_enable -> !$past(ctrl_q[g].single_ended));
    endproperty
    a_type_sel: assert property (p_type_sel) else $error("diff on in se mode"); // R1

    property p_legs;
      @(posedge core_clk) disable iff (!resetn)
        ctrl_q[g].single_ended |=> (drive[g].leg_a_enable == $past(ctrl_q[g].leg_enable[0])
                                   && drive[g].leg_b_enable == $past(ctrl_q[g].leg_enable[1]));
    endproperty
    a_legs: assert property (p_legs) else $error("leg enable mismatch"); // R3

    property p_legs_off;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].single_ended && ctrl_q[g].leg_enable == `ODC_LEG_OFF)
          |=> !drive[g].leg_a_enable && !drive[g].leg_b_enable;
    endproperty
    a_legs_off: assert property (p_legs_off) else $error("leg not tristated"); // R4

    property p_diff_pol;
      @(posedge core_clk) disable iff (!resetn)
        !ctrl_q[g].single_ended |=> (drive[g].leg_a_invert == $past(ctrl_q[g].polarity[0])
                                    && drive[g].leg_b_invert != drive[g].leg_a_invert);
    endproperty
    a_diff_pol: assert property (p_diff_pol) else $error("diff polarity wrong"); // R5

    property p_se_pol;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].single_ended && ctrl_q[g].polarity == `ODC_POL_NI)
          |=> !drive[g].leg_a_invert && drive[g].leg_b_invert;
    endproperty
    a_se_pol: assert property (p_se_pol) else $error("se polarity wrong"); // R5

    property p_swing;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].differential_swing == `ODC_SWING_960)
          |=> swing_mv[g] == 10'(`ODC_SWING_960_MV);
    endproperty
    a_swing: assert property (p_swing) else $error("swing code wrong"); // R6

    property p_pdn;
      @(posedge core_clk) disable iff (!resetn)
        (!ctrl_q[g].single_ended && ctrl_q[g].power_down) |=> !drive[g].diff_enable;
    endproperty
    a_pdn: assert property (p_pdn) else $error("power down ignored"); // R7

    property p_write;
      @(posedge core_clk) disable iff (!resetn)
        (wr_en && hit(addr, g)) |=> ctrl_q[g] == $past(wr_data);
    endproperty
    a_write: assert property (p_write) else $error("write lost"); // R8

    property p_wr_drive;
      @(posedge core_clk) disable iff (!resetn)
        s_wr_ch |-> ##2 drive[g].differential_swing == $past(wr_data[2:1], 2);
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write not applied"); // R8

    property p_rd_ch;
      @(posedge core_clk) disable iff (!resetn)
        s_rd_ch |=> rd_valid && rd_data == $past(ctrl_q[g]);
    endproperty
    a_rd_ch: assert property (p_rd_ch) else $error("readback wrong"); // R8

    property p_hold;
      @(posedge core_clk) disable iff (!resetn)
        !(wr_en && hit(addr, g)) |=> $stable(ctrl_q[g]);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed"); // R8

    property p_se_off;
      @(posedge core_clk) disable iff (!resetn)
        ctrl_q[g].single_ended |=> !drive[g].diff_enable;
    endproperty
    a_se_off: assert property (p_se_off) else $error("diff on in se mode"); // R1

    property p_diff_legs;
      @(posedge core_clk) disable iff (!resetn)
        !ctrl_q[g].single_ended |=> !drive[g].leg_a_enable && !drive[g].leg_b_enable;
    endproperty
    a_diff_legs: assert property (p_diff_legs) else $error("se leg on in diff mode"); // R1

    property p_se_nn;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].single_ended && ctrl_q[g].polarity == `ODC_POL_NN)
          |=> !drive[g].leg_a_invert && !drive[g].leg_b_invert;
    endproperty
    a_se_nn: assert property (p_se_nn) else $error("se polarity wrong"); // R5

    property p_se_ii;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].single_ended && ctrl_q[g].polarity == `ODC_POL_II)
          |=> drive[g].leg_a_invert && drive[g].leg_b_invert;
    endproperty
    a_se_ii: assert property (p_se_ii) else $error("se polarity wrong"); // R5

    property p_se_in;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].single_ended && ctrl_q[g].polarity == `ODC_POL_IN)
          |=> drive[g].leg_a_invert && !drive[g].leg_b_invert;
    endproperty
    a_se_in: assert property (p_se_in) else $error("se polarity wrong"); // R5

    property p_swing_low;
      @(posedge core_clk) disable iff (!resetn)
        (ctrl_q[g].differential_swing == `ODC_SWING_400)
          |=> swing_mv[g] == 10'(`ODC_SWING_400_MV);
    endproperty
    a_swing_low: assert property (p_swing_low) else $error("swing code wrong"); // R6

    property p_diff_on;
      @(posedge core_clk) disable iff (!resetn)
        (!ctrl_q[g].single_ended && !ctrl_q[g].power_down) |=> drive[g].diff_enable;
    endproperty
    a_diff_on: assert property (p_diff_on) else $error("diff driver off"); // R7
  end

  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  property p_rd_strobe;
    @(posedge core_clk) disable iff (!resetn)
      1'b1 |=> rd_valid == $past(rd_en);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("rd_valid wrong"); // R8

  property p_rd_idle;
    @(posedge core_clk) disable iff (!resetn)
      (!rd_en || addr < `ODC_CH0_ADDR || addr > `ODC_CH3_ADDR) |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd_data not zero"); // R8

  property p_reset_drive;
    @(posedge core_clk)
      $rose(resetn) |=> drive[0].diff_enable && !drive[0].leg_a_invert
                        && drive[0].leg_b_invert
                        && drive[0].differential_swing == `ODC_SWING_780;
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("bad reset drive"); // R2

  property p_reset_val;
    @(posedge core_clk) $rose(resetn) |-> ctrl_q[0] == `ODC_RESET_VAL;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value"); // R2
endmodule

/* core/odc_map.svh */
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH
`define ODC_ADDR_W        10
`define ODC_CH0_ADDR      10'h0F0
`define ODC_CH1_ADDR      10'h0F1
`define ODC_CH2_ADDR      10'h0F2
`define ODC_CH3_ADDR      10'h0F3
`define ODC_BIT_TYPE      7
`define ODC_LEG_HI        6
`define ODC_LEG_LO        5
`define ODC_POL_HI        4
`define ODC_POL_LO        3
`define ODC_SWING_HI      2
`define ODC_SWING_LO      1
`define ODC_BIT_PDN       0
`define ODC_RESET_VAL     8'h64
`define ODC_LEG_OFF       2'h0
`define ODC_LEG_A_ONLY    2'h1
`define ODC_LEG_B_ONLY    2'h2
`define ODC_LEG_BOTH      2'h3
`define ODC_POL_NN        2'h0
`define ODC_POL_II        2'h1
`define ODC_POL_NI        2'h2
`define ODC_POL_IN        2'h3
`define ODC_SWING_400     2'h0
`define ODC_SWING_600     2'h1
`define ODC_SWING_780     2'h2
`define ODC_SWING_960     2'h3
`define ODC_SWING_400_MV  400
`define ODC_SWING_600_MV  600
`define ODC_SWING_780_MV  780
`define ODC_SWING_960_MV  960
`endif

/* core/odc_pkg.sv */
package odc_pkg;
  // one channel control register
  typedef struct packed {
    logic       single_ended;
    logic [1:0] leg_enable;
    logic [1:0] polarity;
    logic [1:0] differential_swing;
    logic       power_down;
  } odc_ctrl_t;

  // decoded drive for one channel
  typedef struct packed {
    logic       diff_enable;
    logic       leg_a_enable;
    logic       leg_b_enable;
    logic       leg_a_invert;
    logic       leg_b_invert;
    logic [1:0] differential_swing;
  } odc_drive_t;
endpackage

/* core/odc_channel_decode.sv */
`timescale 1ns/1ps
`include "odc_map.svh"
module odc_channel_decode (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire odc_pkg::odc_ctrl_t  ctrl,
  output odc_pkg::odc_drive_t      drive
);
  import odc_pkg::*;

  odc_drive_t drive_d;

  always_comb begin
    drive_d                    = '0;
    drive_d.differential_swing = ctrl.differential_swing; // R6
    if (!ctrl.single_ended) begin // R1
      drive_d.diff_enable  = !ctrl.power_down; // R7
      drive_d.leg_a_invert = ctrl.polarity[0]; // R5
      drive_d.leg_b_invert = !ctrl.polarity[0]; // R5
    end else begin
      drive_d.leg_a_enable = ctrl.leg_enable[0]; // R3 R4
      drive_d.leg_b_enable = ctrl.leg_enable[1]; // R3 R4
      unique case (ctrl.polarity) // R5
        `ODC_POL_NN: begin
          drive_d.leg_a_invert = 1'b0;
          drive_d.leg_b_invert = 1'b0;
        end
        `ODC_POL_II: begin
          drive_d.leg_a_invert = 1'b1;
          drive_d.leg_b_invert = 1'b1;
        end
        `ODC_POL_NI: begin
          drive_d.leg_a_invert = 1'b0;
          drive_d.leg_b_invert = 1'b1;
        end
        `ODC_POL_IN: begin
          drive_d.leg_a_invert = 1'b1;
          drive_d.leg_b_invert = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive <= '0;
    end else begin
      drive <= drive_d;
    end
  end
endmodule

/* verif/odc_clock_receiver.sv */
`timescale 1ns/1ps
module odc_clock_receiver (
  input  wire logic                      out_clk,
  input  wire odc_pkg::odc_drive_t [3:0] drive,
  output logic [3:0]                     seen_a,
  output logic [3:0]                     seen_b
);
  import odc_pkg::*;
  // a tristated leg is pulled low at the receiver
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      seen_a[c] = drive[c].leg_a_enable & (out_clk ^ drive[c].leg_a_invert);
      seen_b[c] = drive[c].leg_b_enable & (out_clk ^ drive[c].leg_b_invert);
    end
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import odc_pkg::*;
  logic                core_clk, resetn, wr_en, rd_en, rd_valid;
  logic [9:0]          addr;
  logic [7:0]          wr_data, rd_data;
  odc_drive_t [3:0]    drive;
  logic [3:0][9:0]     swing_mv;
  logic [3:0]          seen_a, seen_b;
  logic [7:0]          exp_q[$];
  logic [7:0]          regs[4];
  logic [31:0]         seed = 32'h4;
  logic                out_lvl = 1'b0;
  int                  fails, total_checks, cyc;
  odc_output_driver_control dut_u (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .drive(drive), .swing_mv(swing_mv));
  odc_clock_receiver rx_u (.out_clk(out_lvl), .drive(drive), .seen_a(seen_a), .seen_b(seen_b));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic odc_drive_t dec(logic [7:0] d);
    odc_drive_t r;
    r.diff_enable        = ~d[7] & ~d[0];
    r.leg_a_enable       = d[7] & d[5];
    r.leg_b_enable       = d[7] & d[6];
    r.leg_a_invert       = d[3];
    r.leg_b_invert       = d[7] ? d[3] ^ d[4] : ~d[3];
    r.differential_swing = d[2:1];
    return r;
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    check("pending_reads", 16'(exp_q.size()), 16'h0000);
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
    if (a >= 10'h0F0 && a <= 10'h0F3) regs[a[1:0]] = d;
  endtask
  task automatic rd(logic [9:0] a);
    @(negedge core_clk);
    rd_en = 1'b1;
    addr = a;
    exp_q.push_back((a >= 10'h0F0 && a <= 10'h0F3) ? regs[a[1:0]] : 8'h00);
    @(negedge core_clk);
    rd_en = 1'b0;
  endtask
  task automatic chk_ch(int c);
    logic [9:0] mv[4] = '{10'd400, 10'd600, 10'd780, 10'd960};
    odc_drive_t e;
    e = dec(regs[c]);
    check("drive", 16'(drive[c]), 16'(e));
    check("swing_mv", 16'(swing_mv[c]), 16'(mv[regs[c][2:1]]));
    check("leg_a_seen", 16'(seen_a[c]), 16'(e.leg_a_enable & (out_lvl ^ e.leg_a_invert)));
    check("leg_b_seen", 16'(seen_b[c]), 16'(e.leg_b_enable & (out_lvl ^ e.leg_b_invert)));
  endtask
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("rd_valid", 16'(rd_valid), 16'h0000);
      else check("rd_data", 16'(rd_data), 16'(exp_q.pop_front()));
    end else if (resetn === 1'b1) begin
      check("rd_data_idle", 16'(rd_data), 16'h0000);
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    out_lvl <= ~out_lvl;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    logic [31:0] r;
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wr_data = '0;
    for (int i = 0; i < 2; i++) begin
      regs = '{default: 8'h64};
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      for (int c = 0; c < 4; c++) check("reset_drive", 16'(drive[c]), 16'h0000);
      resetn = 1'b1;
      @(negedge core_clk);
      for (int c = 0; c < 4; c++) chk_ch(c);
      for (int c = 0; c < 4; c++) rd(10'h0F0 + 10'(c));
      $display("test reset_defaults %0d done", i);
      wr(10'h0EF, 8'hFF);
      wr(10'h0F4, 8'h81);
      rd(10'h0EF);
      rd(10'h0F4);
      for (int c = 0; c < 4; c++) chk_ch(c);
      $display("test unmapped done");
      repeat (60) begin
        r = rnd();
        wr(10'h0F0 + 10'(r[9:8]), r[7:0]);
        @(negedge core_clk);
        chk_ch(int'(r[9:8]));
        rd(10'h0F0 + 10'(r[9:8]));
      end
      $display("test random_channels done");
      @(negedge core_clk);
      resetn = 1'b0;
    end
    conclude();
  end
endmodule
